// [eep_ctrl.sv]
/*
 Serial EEPROM slave: command engine for random, current and sequential
 reads, single-byte write with timed internal programming, write protect,
 acknowledge polling, command cancel and a small Avalon-MM status port.
 Assumes SCL/SDA/WP/select pins are asynchronous and SDA has a pull-up.
*/
// Register access over Avalon-MM and the register addresses were left to the implementer.
//  Function
//  - WP high blocks rewrite, reads still allowed
//  - WP high aborts running internal programming
//  - Random read returns byte at given address
//  - Current read uses last address plus one
//  - Master ack low: increment, send next byte
//  - Ack high then stop ends read output
//  - Reset sequences return engine to idle
//  - Busy programming: no address acknowledge
//  - Acknowledge polling reports programming done
//  - WP ignored until first data LSB
//  - WP high after data LSB cancels write
//  - After WP abort, standby immediately
//  - Start then stop cancels command
//  - After cancel, address register not trusted
//  - SDA only pulled low, else released
//  - Respond only when select bits match
//  - Address LSB direction, top nibble type
`timescale 1ns/1ps
`default_nettype none

module eep_ctrl
#(
   // Arbitrary device-type nibble, not a real part code
   parameter logic [3:0]  DEV_TYPE    = 4'h5,
   parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYC
)
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        srst_in,
   // Serial bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n_out,
   // Strap pins
   input  wire logic        wp_in,
   input  wire logic        select_pin_bit0_in,
   input  wire logic        select_pin_bit1_in,
   input  wire logic        select_pin_bit2_in,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out
);

   localparam int unsigned AW = eep_pkg::MEM_AW;
   localparam int unsigned PW = eep_pkg::PROG_CNT_W;
   localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYCLES - 1);

   typedef struct packed {
      eep_pkg::eep_st_t st;
      logic [3:0]       cnt;
      logic [7:0]       sh;
      logic [AW-1:0]    addr;
      logic [AW-1:0]    prog_addr;
      logic [7:0]       wdata;
      logic             have_data;
      logic             armed;
      logic             wp_hit;
      logic             busy;
      logic [PW-1:0]    prog_cnt;
      logic             aborted;
      logic             mem_we;
      logic             drive;
      logic [2:0]       sel_mask;
      logic             av_ack;
      logic [31:0]      rdata;
   } eep_ctrl_t;

   eep_ctrl_t  q;
   eep_ctrl_t  next_q;

   logic       sda_s;
   logic       wp_s;
   logic [2:0] sel_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_c;
   logic       stop_c;
   logic [7:0] mem_rd;
   logic       av_req;

   eep_line_sync u_sync
   (
      .clk_sys_in   (clk_sys_in),
      .srst_in      (srst_in),
      .scl_in       (scl_in),
      .sda_in       (sda_in),
      .wp_in        (wp_in),
      .sel_in       ({select_pin_bit2_in, select_pin_bit1_in, select_pin_bit0_in}),
      .sda_s_out    (sda_s),
      .wp_s_out     (wp_s),
      .sel_s_out    (sel_s),
      .scl_rise_out (scl_rise),
      .scl_fall_out (scl_fall),
      .start_out    (start_c),
      .stop_out     (stop_c)
   );

   eep_mem u_mem
   (
      .clk_sys_in (clk_sys_in),
      .we_in      (q.mem_we),
      .waddr_in   (q.prog_addr),
      .wdata_in   (q.wdata),
      .raddr_in   (q.addr),
      .rdata_out  (mem_rd)
   );

   // Slave address check on a fully shifted byte
   function automatic logic addr_match(input logic [7:0] b, input logic [2:0] pins,
                                       input logic [2:0] mask, input logic [3:0] dtype);
      addr_match = (b[7:4] == dtype) && (((b[3:1] ^ pins) & mask) == 3'h0);
   endfunction : addr_match

   function automatic logic [31:0] reg_read(input logic [3:0] ofs, input eep_ctrl_t s,
                                            input logic wp);
      reg_read = 32'h0;
      case (ofs)
         eep_pkg::OFS_CTRL:
            reg_read[eep_pkg::CTRL_MASK_LSB +: 3] = s.sel_mask;
         eep_pkg::OFS_STATUS:
         begin
            reg_read[eep_pkg::STS_BUSY]    = s.busy;
            reg_read[eep_pkg::STS_WP]      = wp;
            reg_read[eep_pkg::STS_ABORTED] = s.aborted;
         end
         eep_pkg::OFS_ADDR:
            reg_read[AW-1:0] = s.addr;
         default:
            reg_read = 32'h0;
      endcase
   endfunction : reg_read

   assign av_req = avs_read_in | avs_write_in;

   always_comb
   begin
      next_q        = q;
      next_q.mem_we = 1'b0;

      // Register bus: one wait cycle, data registered in the first
      next_q.av_ack = av_req & ~q.av_ack;
      if (av_req && !q.av_ack)
         next_q.rdata = reg_read(avs_address_in, q, wp_s);
      if (avs_write_in && q.av_ack && avs_address_in == eep_pkg::OFS_CTRL
          && avs_byteenable_in[0])
         next_q.sel_mask = avs_writedata_in[eep_pkg::CTRL_MASK_LSB +: 3];

      // Internal programming timer
      if (q.busy)
      begin
         if (wp_s)
         begin
            next_q.busy    = 1'b0;
            next_q.aborted = 1'b1;
         end
         else if (q.prog_cnt == PROG_LAST)
         begin
            next_q.busy   = 1'b0;
            next_q.mem_we = 1'b1;
            next_q.addr   = q.prog_addr + AW'(1);
         end
         else
            next_q.prog_cnt = q.prog_cnt + PW'(1);
      end

      // WP watched from first data LSB on
      if (q.st == eep_pkg::ST_WDAT && q.armed && wp_s)
         next_q.wp_hit = 1'b1;

      if (start_c)
      begin
         next_q.st    = eep_pkg::ST_SLV;
         next_q.cnt   = 4'h0;
         next_q.drive = 1'b0;
      end
      else if (stop_c)
      begin
         // stop outside a full write drops the command
         if (q.st == eep_pkg::ST_WDAT && q.have_data && !q.busy)
         begin
            if (q.wp_hit || wp_s)
               next_q.aborted = 1'b1;
            else
            begin
               next_q.busy      = 1'b1;
               next_q.aborted   = 1'b0;
               next_q.prog_cnt  = '0;
               next_q.prog_addr = q.addr;
            end
         end
         next_q.st    = eep_pkg::ST_IDLE;
         next_q.drive = 1'b0;
      end
      else if (scl_rise && q.st != eep_pkg::ST_IDLE)
      begin
         if (q.cnt != eep_pkg::ACK_SLOT)
         begin
            if (q.st != eep_pkg::ST_RDAT)
               next_q.sh = {q.sh[6:0], sda_s};
            // first arming happens at data LSB
            if (q.st == eep_pkg::ST_WDAT && q.cnt == eep_pkg::LSB_SLOT)
            begin
               next_q.armed  = 1'b1;
               next_q.wp_hit = q.wp_hit | wp_s;
            end
            next_q.cnt = q.cnt + 4'h1;
         end
         else
         begin
            next_q.cnt = 4'h0;
            case (q.st)
               eep_pkg::ST_SLV:
               begin
                  // no response while programming
                  // Follow the acknowledge actually given: programming may end between
                  // the acknowledge fall and this rise, and a silent slave must not talk
                  if (!q.drive)
                     next_q.st = eep_pkg::ST_IDLE;
                  else if (q.sh[0])
                  begin
                     next_q.st   = eep_pkg::ST_RDAT;
                     next_q.sh   = mem_rd;
                     next_q.addr = q.addr + AW'(1);
                  end
                  else
                     next_q.st = eep_pkg::ST_WADR;
               end
               eep_pkg::ST_WADR:
               begin
                  // word address sets the read point
                  next_q.addr      = q.sh;
                  next_q.st        = eep_pkg::ST_WDAT;
                  next_q.have_data = 1'b0;
                  next_q.armed     = 1'b0;
                  next_q.wp_hit    = 1'b0;
               end
               eep_pkg::ST_WDAT:
               begin
                  next_q.wdata     = q.sh;
                  next_q.have_data = 1'b1;
               end
               eep_pkg::ST_RDAT:
               begin
                  if (!sda_s)
                  begin
                     next_q.sh   = mem_rd;
                     next_q.addr = q.addr + AW'(1);
                  end
                  else
                     next_q.st = eep_pkg::ST_IDLE;
               end
               default:
                  next_q.st = eep_pkg::ST_IDLE;
            endcase
         end
      end
      else if (scl_fall)
      begin
         case (q.st)
            eep_pkg::ST_SLV:
               // ack only when idle and addressed
               next_q.drive = (q.cnt == eep_pkg::ACK_SLOT) && !q.busy
                              && addr_match(q.sh, sel_s, q.sel_mask, DEV_TYPE);
            eep_pkg::ST_WADR,
            eep_pkg::ST_WDAT:
               next_q.drive = (q.cnt == eep_pkg::ACK_SLOT);
            eep_pkg::ST_RDAT:
               next_q.drive = (q.cnt != eep_pkg::ACK_SLOT) && !q.sh[3'(7 - q.cnt)];
            default:
               next_q.drive = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         q          <= '0;
         q.st       <= eep_pkg::ST_IDLE;
         q.sel_mask <= eep_pkg::CTRL_MASK_RST;
      end
      else
         q <= next_q;
   end

   assign sda_out             = 1'b0;
   assign sda_oe_n_out        = ~q.drive;
   assign avs_readdata_out    = q.rdata;
   assign avs_waitrequest_out = av_req & ~q.av_ack;

endmodule : eep_ctrl

`default_nettype wire

// [eep_ctrl_assertions.sv]
/*
 Pin and register-port checks for eep_ctrl.
 Assumes the bench resolves the data wire and feeds it to sda_in.
*/
`timescale 1ns/1ps
`default_nettype none
module eep_ctrl_assertions
(
   // Clock, reset and serial pins
   input wire logic        clk_sys_in,
   input wire logic        srst_in,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe_n_out,
   // Register port
   input wire logic [3:0]  avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);
   sequence start_s;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   sequence stop_s;
      scl_in && $past(scl_in) && $rose(sda_in);
   endsequence
   sequence req_s;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence done_s;
      avs_read_in && !avs_waitrequest_out;
   endsequence
   line_low_a: assert property (sda_out == 1'b0)
      else $error("data output not low");
   start_free_a: assert property (start_s |-> sda_oe_n_out [*8])
      else $error("data line held after start");
   stop_free_a: assert property (stop_s |-> sda_oe_n_out [*8])
      else $error("data line held after stop");
   // Grabbing the line while the clock is high would fake a start
   drive_scl_low_a: assert property ($fell(sda_oe_n_out) |-> !scl_in)
      else $error("data drive began with clock high");
   // Letting go while the clock is high would fake a stop
   release_scl_low_a: assert property ($rose(sda_oe_n_out) |-> !scl_in)
      else $error("data release with clock high");
   one_wait_a: assert property (req_s |=> !avs_waitrequest_out)
      else $error("register answer late");
   idle_wait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
      else $error("wait raised without request");
   unmapped_zero_a: assert property (done_s ##0 (avs_address_in == 4'hC)
                                     |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (done_s |=> $stable(avs_readdata_out))
      else $error("read data moved after transfer");
endmodule : eep_ctrl_assertions
bind eep_ctrl eep_ctrl_assertions chk_u
(
   .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out)
);
`default_nettype wire

// [eep_i2c_master.sv]
/*
 Serial bus master model: start, stop, bit and byte tasks, 48 ns clock
 that stands high between frames. Assumes a pull-up on the data wire.
*/
`timescale 1ns/1ps
`default_nettype none
module eep_i2c_master
(
   // Serial bus
   output logic      scl_out,
   output logic      sda_out,
   input  wire logic sda_in
);
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic start();
      sda_out = 1'b1;
      #12 scl_out = 1'b1;
      #12 sda_out = 1'b0;
      #12 scl_out = 1'b0;
      #12;
   endtask : start
   task automatic stop();
      sda_out = 1'b0;
      #12 scl_out = 1'b1;
      #12 sda_out = 1'b1;
      #12;
   endtask : stop
   task automatic bit_x(input logic b, output logic r);
      sda_out = b;
      #12 scl_out = 1'b1;
      #12 r = sda_in;
      #12 scl_out = 1'b0;
      #12;
   endtask : bit_x
   task automatic send(input logic [7:0] d, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, ak);
   endtask : send
   task automatic recv(input logic nk, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(nk, r);
   endtask : recv
endmodule : eep_i2c_master
`default_nettype wire

// [eep_line_sync.sv]
/*
 Pin conditioner: two-flop synchronisers for the bus and strap pins,
 clock edge pulses and start/stop condition pulses.
 Assumes all inputs are asynchronous to clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none

module eep_line_sync
(
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       srst_in,
   // Raw pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       wp_in,
   input  wire logic [2:0] sel_in,
   // Conditioned
   output logic            sda_s_out,
   output logic            wp_s_out,
   output logic [2:0]      sel_s_out,
   output logic            scl_rise_out,
   output logic            scl_fall_out,
   output logic            start_out,
   output logic            stop_out
);

   typedef struct packed {
      logic [5:0] m1;
      logic [5:0] m2;
      logic       scl_d;
      logic       sda_d;
   } eep_sync_t;

   eep_sync_t q;
   eep_sync_t next_q;

   // First stage feeds only the second stage
   always_comb
   begin
      next_q       = q;
      next_q.m1    = {sel_in, wp_in, sda_in, scl_in};
      next_q.m2    = q.m1;
      next_q.scl_d = q.m2[0];
      next_q.sda_d = q.m2[1];
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         q <= '{m1: 6'h3F, m2: 6'h3F, scl_d: 1'b1, sda_d: 1'b1};
      else
         q <= next_q;
   end

   assign sda_s_out    = q.m2[1];
   assign wp_s_out     = q.m2[2];
   assign sel_s_out    = q.m2[5:3];
   assign scl_rise_out = q.m2[0] & ~q.scl_d;
   assign scl_fall_out = ~q.m2[0] & q.scl_d;
   assign start_out    = q.m2[0] & q.scl_d & q.sda_d & ~q.m2[1];
   assign stop_out     = q.m2[0] & q.scl_d & ~q.sda_d & q.m2[1];

endmodule : eep_line_sync

`default_nettype wire

// [eep_mem.sv]
/*
 Byte array of the EEPROM with one write port and a registered read port.
 Assumes the read address is stable for at least one clock before use.
*/
`timescale 1ns/1ps
`default_nettype none

module eep_mem
(
   // Clock
   input  wire logic                     clk_sys_in,
   // Write port
   input  wire logic                     we_in,
   input  wire logic [eep_pkg::MEM_AW-1:0] waddr_in,
   input  wire logic [7:0]               wdata_in,
   // Read port
   input  wire logic [eep_pkg::MEM_AW-1:0] raddr_in,
   output logic [7:0]                    rdata_out
);

   typedef struct packed {
      logic [7:0] rd;
   } eep_mem_st_t;

   logic [7:0]  cells [eep_pkg::MEM_DEPTH];
   eep_mem_st_t q;
   eep_mem_st_t next_q;

   always_comb
   begin
      next_q    = q;
      next_q.rd = cells[raddr_in];
   end

   // No reset on the array: contents survive a bus reset
   always_ff @(posedge clk_sys_in)
   begin
      q <= next_q;
      if (we_in)
         cells[waddr_in] <= wdata_in;
   end

   assign rdata_out = q.rd;

endmodule : eep_mem

`default_nettype wire

// [eep_pkg.sv]
/*
 Shared constants for the serial EEPROM slave: register map, reset values,
 field positions, timing counts and the command state type.
 Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
*/
`default_nettype none

package eep_pkg;

   // Clock and internal program time
   localparam int unsigned CLK_PERIOD_NS  = 5;
   localparam int unsigned PROG_TIME_NS   = 5000000;
   localparam int unsigned PROG_CYC       = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned PROG_CNT_W     = 20;

   // Memory geometry
   localparam int unsigned MEM_AW         = 8;
   localparam int unsigned MEM_DEPTH      = 256;

   // Register byte offsets
   localparam logic [3:0]  OFS_CTRL       = 4'h0;
   localparam logic [3:0]  OFS_STATUS     = 4'h4;
   localparam logic [3:0]  OFS_ADDR       = 4'h8;

   // Control fields and reset values
   localparam int unsigned CTRL_MASK_LSB  = 0;
   localparam logic [2:0]  CTRL_MASK_RST  = 3'h7;

   // Status field positions
   localparam int unsigned STS_BUSY       = 0;
   localparam int unsigned STS_WP         = 1;
   localparam int unsigned STS_ABORTED    = 2;

   // Index of the acknowledge clock, index of the data LSB clock
   localparam logic [3:0]  ACK_SLOT       = 4'h8;
   localparam logic [3:0]  LSB_SLOT       = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SLV,
      ST_WADR,
      ST_WDAT,
      ST_RDAT
   } eep_st_t;

endpackage : eep_pkg

`default_nettype wire

// [test_eep_ctrl.sv]
/*
 Bench for eep_ctrl: registers, writes with polling, reads, write
 protect, cancel and reset sequences. Assumes the bus master model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_eep_ctrl;
   logic        clk_sys_in = 0;
   logic        srst_in = 1;
   logic        wp = 0;
   logic [2:0]  sel = 3'h0;
   logic [3:0]  adr = 4'h0;
   logic        rd = 0;
   logic        wr = 0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  be = 4'hF;
   logic [31:0] q, aq;
   logic        wt, scl, m_sda, d_sda, d_oe_n, ak;
   wire         sda = m_sda & (d_oe_n | d_sda);
   int          err_total = 0;
   int          checked = 0;
   int          n;
   logic [31:0] rs = 32'h1C;
   logic [7:0]  mem [256];
   logic [7:0]  b, v;
   always #2.5 clk_sys_in = ~clk_sys_in;
   eep_ctrl #(.PROG_CYCLES(200)) dut_u
   (
      .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
      .sda_out(d_sda), .sda_oe_n_out(d_oe_n), .wp_in(wp),
      .select_pin_bit0_in(sel[0]), .select_pin_bit1_in(sel[1]),
      .select_pin_bit2_in(sel[2]), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
      .avs_readdata_out(aq), .avs_waitrequest_out(wt)
   );
   eep_i2c_master m_u (.scl_out(scl), .sda_out(m_sda), .sda_in(sda));
   function automatic logic [7:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[7:0];
   endfunction : rnd
   function automatic logic [7:0] hdr(input logic r);
      return {4'h5, sel, r};
   endfunction : hdr
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      do @(posedge clk_sys_in); while (wt);
      q = aq;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic sx(input logic [7:0] d, input logic e);
      m_u.send(d, ak);
      chk(32'(ak), 32'(e));
   endtask : sx
   task automatic wcell(input logic [7:0] a, input logic [7:0] d, input logic p);
      m_u.start();
      sx(hdr(0), 0);
      sx(a, 0);
      @(posedge clk_sys_in);
      wp <= p;
      m_u.send(d, ak);
      m_u.stop();
   endtask : wcell
   task automatic poll(input logic r);
      n = 0;
      do
      begin
         m_u.start();
         m_u.send(hdr(r), ak);
         if (!ak && r)
            m_u.recv(1'b1, v);
         m_u.stop();
         n++;
      end
      while (ak && n < 40);
      chk(32'(ak), 0);
   endtask : poll
   task automatic rdseq(input logic [7:0] a, input int k);
      m_u.start();
      sx(hdr(1), 0);
      for (int i = 0; i < k; i++)
      begin
         m_u.recv(i == k - 1, v);
         chk(32'(v), 32'(mem[8'(a + i)]));
      end
      m_u.stop();
   endtask : rdseq
   task automatic rrd(input logic [7:0] a, input int k);
      m_u.start();
      sx(hdr(0), 0);
      sx(a, 0);
      rdseq(a, k);
   endtask : rrd
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   initial
   begin
      #300us;
      err_total++;
      close_out();
   end
   initial
   begin
      @(posedge clk_sys_in);
      sel <= 3'(rnd());
      b = rnd();
      repeat (15) @(posedge clk_sys_in);
      srst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      bus(0, eep_pkg::OFS_STATUS, 0);
      chk(q, 0);
      be <= 4'h0;
      bus(1, eep_pkg::OFS_CTRL, 0);
      be <= 4'hF;
      bus(1, 4'hC, 32'hFF);
      bus(0, 4'hC, 0);
      chk(q, 0);
      bus(0, eep_pkg::OFS_CTRL, 0);
      chk(q, 32'h7);
      // Descending order keeps the byte after each write known
      for (int i = 5; i >= 0; i--)
      begin
         mem[8'(b + i)] = rnd();
         wcell(8'(b + i), mem[8'(b + i)], 0);
         poll(i < 5);
         chk(32'(n > 1), 1);
         if (i < 5)
            chk(32'(v), 32'(mem[8'(b + i + 1)]));
      end
      rrd(b, 3);
      rdseq(8'(b + 3), 2);
      bus(0, eep_pkg::OFS_ADDR, 0);
      chk(q, 32'(8'(b + 5)));
      wp <= 1'b1;
      mem[b] = ~mem[b];
      wcell(b, mem[b], 0);
      poll(0);
      wcell(8'(b + 1), ~mem[8'(b + 1)], 1);
      bus(0, eep_pkg::OFS_STATUS, 0);
      chk(q, 32'h6);
      poll(0);
      chk(n, 1);
      wp <= 1'b0;
      rrd(b, 2);
      wcell(8'(b + 2), 8'h0, 0);
      repeat (20) @(posedge clk_sys_in);
      wp <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
      bus(0, eep_pkg::OFS_STATUS, 0);
      chk(q, 32'h6);
      poll(0);
      chk(n, 1);
      wp <= 1'b0;
      bus(1, eep_pkg::OFS_CTRL, 0);
      m_u.start();
      sx({4'h5, ~sel, 1'b0}, 0);
      m_u.stop();
      bus(1, eep_pkg::OFS_CTRL, 7);
      for (int k = 0; k < 4; k++)
      begin
         m_u.start();
         sx(k < 3 ? {4'h5, sel ^ 3'(1 << k), 1'b0} : {4'h3, sel, 1'b0}, 1);
         m_u.stop();
      end
      m_u.start();
      sx(hdr(0), 0);
      sx(b, 0);
      repeat (4) m_u.bit_x(1'b0, ak);
      m_u.start();
      m_u.stop();
      poll(0);
      chk(n, 1);
      rrd(b, 1);
      for (int k = 0; k < 3; k++)
      begin
         m_u.start();
         sx(hdr(0), 0);
         sx(b, 0);
         m_u.start();
         sx(hdr(1), 0);
         repeat (3) m_u.bit_x(1'b1, ak);
         if (k == 1)
            m_u.start();
         if (k < 2)
            repeat (9) m_u.bit_x(1'b1, ak);
         repeat (k == 0 ? 2 : (k == 1 ? 1 : 9)) m_u.start();
         rrd(b, 1);
      end
      close_out();
   end
endmodule : test_eep_ctrl
`default_nettype wire
